// file: design/sdrmux_top.sv
// Purpose: Row/column address multiplexer for SDRAM areas 2 and 3 on a 32-bit bus.
// Assumes: One 10 MHz clock, synchronous active-low reset, AHB-Lite register access.
// Notes: Only the 12x10 and 13x9 geometries are served; others refuse requests.
//
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`include "sdrmux_cfg.svh"

// Contract
// - In the 32-bit 12-row 10-column geometry the row cycle drives pins 17..0 with address 27..10.
// - In that geometry the column cycle drives same-numbered bits, but pins 15/14 carry 25/24.
// - In the column cycle pin 12 carries the request's autoPre bit, set per request, not an address.
// - When address bit 25 selects the bank, only the lower row strobe is asserted.
// - In the 32-bit 13-row 9-column geometry the row cycle drives pins 17..0 with address 26..9.
// - In that geometry pins 16/15 carry bits 25/24 in both cycles, pin 12 the command bit in the column cycle only.
module sdrmux_top #(
    parameter int CYCLE_CLOCKS = `SDRMUX_CYCLE_CLOCKS
) (
    input wire logic clock,
    input wire logic rst_b,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Access request.
    input wire logic cmdValid,
    input wire sdrmux_pkg::sdrmux_req_t cmdReq,
    output logic cmdReady,
    // Memory side.
    output logic [17:0] memAddr,
    output logic row_strobe_lower_n,
    output logic row_strobe_upper_n,
    output logic colCycle
);

    // ****************************************************************
    // Elaboration checks.
    // ****************************************************************

    // A cycle must last at least one clock and fit the counter.
    if (CYCLE_CLOCKS < 1 || CYCLE_CLOCKS > 255) begin : gCycleRange
        $error("CYCLE_CLOCKS must lie between 1 and 255.");
    end

    // ****************************************************************
    // Mapping functions.
    // ****************************************************************

    // True when the geometry is one of the two served layouts.
    function automatic logic geomOk(input sdrmux_pkg::sdrmux_geom_t g);
        logic ok;
        ok = 1'b0;
        if (g.areaBusWidthSel == `SDRMUX_BSZ_32) begin
            if (g.areaRowBitsSel == `SDRMUX_ROW_12 && g.areaColBitsSel == `SDRMUX_COL_10) begin
                ok = 1'b1;
            end
            if (g.areaRowBitsSel == `SDRMUX_ROW_13 && g.areaColBitsSel == `SDRMUX_COL_9) begin
                ok = 1'b1;
            end
        end
        return ok;
    endfunction : geomOk

    // True whenever the row field selects 13 rows; the column and bus fields are not looked at.
    function automatic logic geomIs13(input sdrmux_pkg::sdrmux_geom_t g);
        return g.areaRowBitsSel == `SDRMUX_ROW_13;
    endfunction : geomIs13

    // Unpacks the geometry fields from a bus word; other bits are ignored.
    function automatic sdrmux_pkg::sdrmux_geom_t geomFromWord(input logic [31:0] w);
        sdrmux_pkg::sdrmux_geom_t g;
        g.areaBusWidthSel = w[`SDRMUX_GEOM_BSZ_LSB +: 2];
        g.areaRowBitsSel = w[`SDRMUX_GEOM_ROW_LSB +: 2];
        g.areaColBitsSel = w[`SDRMUX_GEOM_COL_LSB +: 2];
        return g;
    endfunction : geomFromWord

    // Pin values during the row cycle.
    function automatic logic [17:0] rowMap(input sdrmux_pkg::sdrmux_geom_t g,
                                           input logic [27:0] a);
        logic [17:0] p;
        p = a[27:10];
        if (geomIs13(g)) begin
            p = a[26:9];
        end
        return p;
    endfunction : rowMap

    // Pin values during the column cycle.
    function automatic logic [17:0] colMap(input sdrmux_pkg::sdrmux_geom_t g,
                                           input logic [27:0] a,
                                           input logic ap);
        logic [17:0] p;
        p = a[17:0];
        if (geomIs13(g)) begin
            p[16] = a[25];
            p[15] = a[24];
        end else begin
            p[15] = a[25];
            p[14] = a[24];
        end
        p[12] = ap;
        return p;
    endfunction : colMap

    // ****************************************************************
    // Register file.
    // ****************************************************************

    sdrmux_pkg::sdrmux_geom_t geom_q;
    sdrmux_pkg::sdrmux_state_t state_q;
    sdrmux_pkg::sdrmux_req_t req_q;
    logic [7:0] cnt_q;
    logic wrPend_q;
    logic [7:0] wrAddr_q;
    logic [31:0] hrdata_q;
    logic addrPhase;
    logic cycleEnd;
    logic cmdAccept;

    // A transfer's address phase is taken whenever the bus is ready.
    assign addrPhase = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // Latches a write's address for its data phase.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
        end else if (hready) begin
            wrPend_q <= addrPhase && hwrite;
            wrAddr_q <= haddr[7:0];
        end
    end

    // Geometry register, written in the data phase; unused bits are ignored.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            geom_q.areaBusWidthSel <= `SDRMUX_RST_BSZ;
            geom_q.areaRowBitsSel <= `SDRMUX_RST_ROW;
            geom_q.areaColBitsSel <= `SDRMUX_RST_COL;
        end else if (wrPend_q && wrAddr_q == `SDRMUX_OFF_GEOM) begin
            geom_q <= geomFromWord(hwdata);
        end
    end

    // Read data is captured at the address phase; unmapped offsets read zero.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addrPhase && !hwrite) begin
            case (haddr[7:0])
                `SDRMUX_OFF_GEOM: begin
                    // A write in its data phase is forwarded so a pipelined read sees it.
                    if (wrPend_q && wrAddr_q == `SDRMUX_OFF_GEOM) begin
                        hrdata_q <= {26'h000_0000, geomFromWord(hwdata)};
                    end else begin
                        hrdata_q <= {26'h000_0000, geom_q};
                    end
                end
                `SDRMUX_OFF_STATUS: begin
                    hrdata_q <= {28'h000_0000, colCycle, state_q != sdrmux_pkg::SM_IDLE,
                                 geomIs13(geom_q), geomOk(geom_q)};
                end
                `SDRMUX_OFF_PINS: begin
                    hrdata_q <= {12'h000, row_strobe_upper_n, row_strobe_lower_n, memAddr};
                end
                default: begin
                    hrdata_q <= 32'h0000_0000;
                end
            endcase
        end
    end

    // ****************************************************************
    // Access sequencer.
    // ****************************************************************

    // Requests are refused while busy or while the geometry is not served.
    assign cmdReady = state_q == sdrmux_pkg::SM_IDLE && geomOk(geom_q);
    assign cmdAccept = cmdValid && cmdReady;
    assign cycleEnd = cnt_q == 8'(CYCLE_CLOCKS - 1);

    // Walks one row cycle then one column cycle per accepted request.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_q <= sdrmux_pkg::SM_IDLE;
            cnt_q <= 8'h00;
            req_q <= '0;
        end else begin
            case (state_q)
                sdrmux_pkg::SM_IDLE: begin
                    cnt_q <= 8'h00;
                    if (cmdAccept) begin
                        req_q <= cmdReq;
                        state_q <= sdrmux_pkg::SM_ROW;
                    end
                end
                sdrmux_pkg::SM_ROW: begin
                    cnt_q <= cycleEnd ? 8'h00 : cnt_q + 8'h01;
                    if (cycleEnd) begin
                        state_q <= sdrmux_pkg::SM_COL;
                    end
                end
                sdrmux_pkg::SM_COL: begin
                    cnt_q <= cycleEnd ? 8'h00 : cnt_q + 8'h01;
                    if (cycleEnd) begin
                        state_q <= sdrmux_pkg::SM_IDLE;
                    end
                end
                default: begin
                    state_q <= sdrmux_pkg::SM_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Memory pins.
    // ****************************************************************

    // Address pins load once at the start of each cycle and hold until the next.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            memAddr <= 18'h0_0000;
        end else begin
            case (state_q)
                sdrmux_pkg::SM_IDLE: begin
                    if (cmdAccept) begin
                        memAddr <= rowMap(geom_q, cmdReq.addr);
                    end
                end
                sdrmux_pkg::SM_ROW: begin
                    if (cycleEnd) begin
                        memAddr <= colMap(geom_q, req_q.addr, req_q.autoPre);
                    end
                end
                default: begin
                    memAddr <= memAddr;
                end
            endcase
        end
    end

    // The lower strobe spans exactly the row cycle of an accepted request.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            row_strobe_lower_n <= 1'b1;
        end else begin
            case (state_q)
                sdrmux_pkg::SM_IDLE: begin
                    if (cmdAccept) begin
                        row_strobe_lower_n <= 1'b0;
                    end
                end
                sdrmux_pkg::SM_ROW: begin
                    if (cycleEnd) begin
                        row_strobe_lower_n <= 1'b1;
                    end
                end
                default: begin
                    row_strobe_lower_n <= 1'b1;
                end
            endcase
        end
    end

    // The column flag spans exactly the column cycle, so the far side knows when to latch.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            colCycle <= 1'b0;
        end else begin
            case (state_q)
                sdrmux_pkg::SM_ROW: begin
                    if (cycleEnd) begin
                        colCycle <= 1'b1;
                    end
                end
                sdrmux_pkg::SM_COL: begin
                    if (cycleEnd) begin
                        colCycle <= 1'b0;
                    end
                end
                default: begin
                    colCycle <= 1'b0;
                end
            endcase
        end
    end

    // Both served layouts take the bank from bit 25, so the upper strobe stays off.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            row_strobe_upper_n <= 1'b1;
        end else begin
            row_strobe_upper_n <= 1'b1;
        end
    end

endmodule : sdrmux_top

// file: common/sdrmux_cfg.svh
// Purpose: Constants of the synchronous DRAM row/column address multiplexer.
// Assumes: Included by its bare name wherever the values are needed.
// Notes: Offsets are byte addresses on the register bus.
`ifndef SDRMUX_CFG_SVH
`define SDRMUX_CFG_SVH

// Register byte offsets.
`define SDRMUX_OFF_GEOM 8'h00
`define SDRMUX_OFF_STATUS 8'h04
`define SDRMUX_OFF_PINS 8'h08

// Geometry field positions in the geometry register.
`define SDRMUX_GEOM_BSZ_LSB 0
`define SDRMUX_GEOM_ROW_LSB 2
`define SDRMUX_GEOM_COL_LSB 4

// Field encodings.
`define SDRMUX_BSZ_32 2'h3
`define SDRMUX_ROW_12 2'h1
`define SDRMUX_ROW_13 2'h2
`define SDRMUX_COL_9 2'h1
`define SDRMUX_COL_10 2'h2

// Reset values of the geometry fields.
`define SDRMUX_RST_BSZ 2'h3
`define SDRMUX_RST_ROW 2'h1
`define SDRMUX_RST_COL 2'h2

// Clocks spent in each of the row and column cycles.
`define SDRMUX_CYCLE_CLOCKS 4

`endif

// file: common/sdrmux_pkg.sv
// Purpose: Types shared by the address multiplexer and its users.
// Assumes: Nothing beyond the SystemVerilog language.
// Notes: Constants live in sdrmux_cfg.svh.
package sdrmux_pkg;

    // Geometry selection fields of one memory area.
    typedef struct packed {
        logic [1:0] areaColBitsSel;
        logic [1:0] areaRowBitsSel;
        logic [1:0] areaBusWidthSel;
    } sdrmux_geom_t;

    // One access request from the bus state controller.
    typedef struct packed {
        logic [27:0] addr;
        logic autoPre;
    } sdrmux_req_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        SM_IDLE,
        SM_ROW,
        SM_COL
    } sdrmux_state_t;

endpackage : sdrmux_pkg

// file: test/sdrmux_properties.sv
// Purpose: Port checks of the SDRAM address multiplexer.
// Assumes: Bound to sdrmux_top; geometry is followed by watching bus writes.
// Notes: Only the 12x10 and 13x9 layouts are served.
module sdrmux_properties #(
    parameter int CYCLE_CLOCKS = 4
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic cmdValid,
    input wire sdrmux_pkg::sdrmux_req_t cmdReq,
    input wire logic cmdReady,
    input wire logic [17:0] memAddr,
    input wire logic row_strobe_lower_n,
    input wire logic row_strobe_upper_n,
    input wire logic colCycle
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wrQ;
    logic [5:0] geomQ;
    logic [7:0] rowCntQ;
    sdrmux_pkg::sdrmux_req_t reqQ;
    logic wide;
    logic deep;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Geometry as last written; the layout after reset is 12x10.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wrQ <= 1'b0;
            geomQ <= 6'h27;
        end else begin
            wrQ <= hsel && htrans[1] && hwrite && haddr == 32'h0000_0000;
            if (wrQ) begin
                geomQ <= hwdata[5:0];
            end
        end
    end
    // Keeps the accepted request and counts the clocks of a row cycle.
    always_ff @(posedge clock) begin
        if (cmdValid && cmdReady) begin
            reqQ <= cmdReq;
        end
        rowCntQ <= row_strobe_lower_n ? 8'h00 : rowCntQ + 8'h01;
    end
    assign wide = geomQ == 6'h27;
    assign deep = geomQ == 6'h1B;
    a_row_map_wide:
        assert property (cmdValid && cmdReady && wide |=> !row_strobe_lower_n
            && memAddr == $past(cmdReq.addr[27:10])) else $error("row map 12x10 wrong");
    a_row_map_deep:
        assert property (cmdValid && cmdReady && deep |=> !row_strobe_lower_n
            && memAddr == $past(cmdReq.addr[26:9])) else $error("row map 13x9 wrong");
    a_col_map_wide:
        assert property (colCycle && wide |-> memAddr == {reqQ.addr[17:16],
            reqQ.addr[25:24], reqQ.addr[13], reqQ.autoPre, reqQ.addr[11:0]})
            else $error("column map 12x10 wrong");
    a_col_map_deep:
        assert property (colCycle && deep |-> memAddr == {reqQ.addr[17],
            reqQ.addr[25:24], reqQ.addr[14:13], reqQ.autoPre, reqQ.addr[11:0]})
            else $error("column map 13x9 wrong");
    a_upper_strobe_idle:
        assert property (row_strobe_upper_n) else $error("upper strobe asserted");
    a_row_then_col:
        assert property ($rose(row_strobe_lower_n) |-> colCycle && rowCntQ == CYCLE_CLOCKS)
            else $error("row cycle length wrong");
    a_busy_refuse:
        assert property (!row_strobe_lower_n || colCycle || !(wide || deep) |-> !cmdReady)
            else $error("request taken while busy or unserved");
endmodule : sdrmux_properties

bind sdrmux_top sdrmux_properties #(.CYCLE_CLOCKS(CYCLE_CLOCKS)) sdrmux_properties_i (
    .clock, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hwdata, .cmdValid, .cmdReq,
    .cmdReady, .memAddr, .row_strobe_lower_n, .row_strobe_upper_n, .colCycle);

// file: test/sdrmux_mem_model.sv
// Purpose: Far-side SDRAM stand-in that latches the row, bank and column it is given.
// Assumes: A row opens on the lower strobe; the column is taken while colCycle is high.
// Notes: deep selects the 13x9 bank pins, otherwise the 12x10 ones.
module sdrmux_mem_model (
    input wire logic clock,
    input wire logic deep,
    input wire logic [17:0] memAddr,
    input wire logic row_strobe_lower_n,
    input wire logic colCycle,
    output logic [1:0] bankSeen,
    output logic [17:0] rowSeen,
    output logic [17:0] colSeen
);
    timeunit 1ns;
    timeprecision 1ns;
    // Opens the row on the lower strobe only and reads the column later.
    always_ff @(posedge clock) begin
        if (!row_strobe_lower_n) begin
            rowSeen <= memAddr;
            bankSeen <= deep ? memAddr[16:15] : memAddr[15:14];
        end
        if (colCycle) begin
            colSeen <= memAddr;
        end
    end
endmodule : sdrmux_mem_model

// file: test/sdrmux_top_tb_top.sv
// Purpose: Self-checking bench of the SDRAM address multiplexer.
// Assumes: One bus master; row and column cycles shortened to 2 clocks.
// Notes: Expected pin values are built from the request address here.
module sdrmux_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic cmdValid = 1'b0;
    sdrmux_pkg::sdrmux_req_t cmdReq = '0;
    logic cmdReady;
    logic [17:0] memAddr;
    logic row_strobe_lower_n;
    logic row_strobe_upper_n;
    logic colCycle;
    logic deep = 1'b0;
    logic [1:0] bankSeen;
    logic [17:0] rowSeen;
    logic [17:0] colSeen;
    logic [31:0] rd;
    logic [27:0] addrs [3] = '{28'h3C0_1F03, 28'h9A5_4AA5, 28'h6F0_D3F0};
    int errCount = 0;
    int nCompared = 0;
    int cycles = 0;
    always #50 clock = ~clock;
    assign hready = hreadyout;
    sdrmux_top #(.CYCLE_CLOCKS(2)) sdrmux_top_i (
        .clock, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .cmdValid, .cmdReq, .cmdReady, .memAddr,
        .row_strobe_lower_n, .row_strobe_upper_n, .colCycle);
    sdrmux_mem_model sdrmux_mem_model_i (.clock, .deep, .memAddr, .row_strobe_lower_n,
        .colCycle, .bankSeen, .rowSeen, .colSeen);
    // Column pins that the rules give for an address in either served layout.
    function automatic logic [17:0] colExp(input logic [27:0] a, input logic ap, input logic d);
        if (d) begin
            return {a[17], a[25:24], a[14:13], ap, a[11:0]};
        end
        return {a[17:16], a[25:24], a[13], ap, a[11:0]};
    endfunction : colExp
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    // One single-word bus transfer; read data lands in rd.
    task automatic ahb(input logic wr, input logic [31:0] ad, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= ad;
        hwrite <= wr;
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb
    // One access; compares what the memory saw with the layout's mapping.
    task automatic access(input logic [27:0] a, input logic ap);
        cmdReq <= '{addr: a, autoPre: ap};
        cmdValid <= 1'b1;
        do @(negedge clock); while (cmdReady !== 1'b1);
        @(posedge clock);
        cmdValid <= 1'b0;
        do @(negedge clock); while (colCycle !== 1'b1);
        do @(negedge clock); while (colCycle !== 1'b0);
        check(32'(rowSeen), 32'(deep ? a[26:9] : a[27:10]));
        check(32'(bankSeen), 32'(a[25:24]));
        check(32'(colSeen), 32'(colExp(a, ap, deep)));
        check(32'(row_strobe_upper_n), 32'h0000_0001);
        @(posedge clock);
    endtask : access
    // Cuts a hung run short.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            errCount++;
            conclude();
        end
    end
    // Main sequence: reset, both layouts, then an unserved layout.
    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
        check(rd, 32'h0000_0027);
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        check(32'(hresp), 32'h0000_0000);
        $display("reset test done");
        foreach (addrs[i]) access(addrs[i], i[0]);
        $display("12x10 test done");
        ahb(1'b1, 32'h0000_0000, 32'h0000_001B);
        deep <= 1'b1;
        foreach (addrs[i]) access(addrs[i], ~i[0]);
        ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
        check(rd, {12'h000, 2'b11, colExp(addrs[2], 1'b1, 1'b1)});
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
        check(rd, 32'h0000_0003);
        $display("13x9 test done");
        ahb(1'b1, 32'h0000_0000, 32'h0000_0017);
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
        check(32'(rd[0]), 32'h0000_0000);
        check(32'(cmdReady), 32'h0000_0000);
        ahb(1'b0, 32'h0000_000C, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        $display("refusal test done");
        conclude();
    end
endmodule : sdrmux_top_tb_top
